/* File: rtab_host_model.sv */
`timescale 1ns/10ps
// Host side of the register port, one transfer at a time.
module rtab_host_model
(
    // Clock and answer.
    input  wire logic        i_clk,
    input  wire logic [23:0] i_rdata,
    // Requests.
    output logic             o_wr,
    output logic             o_rd,
    output logic [5:0]       o_addr,
    output logic [23:0]      o_wdata
);
    // Idle lines; released lines flip so a stale value never looks valid.
    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 6'h3F;
        o_wdata = 24'h000000;
    end

    // A write is held from just after one edge to just after the next.
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(posedge i_clk);
        #1;
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : wr

    // The answer is registered, so it stands just after the edge that took the read.
    task automatic rd(input logic [5:0] a, output logic [23:0] d);
        @(posedge i_clk);
        #1;
        o_rd = 1'b1;
        o_addr = a;
        @(posedge i_clk);
        #1;
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rdata;
    endtask : rd
endmodule : rtab_host_model

/* File: rtab_pkg.sv */
package rtab_pkg;

    // Register addresses on the control bus.
    localparam logic [5:0] ADDR_SCRATCH_B = 6'h11;
    localparam logic [5:0] ADDR_SCRATCH_C = 6'h12;
    localparam logic [5:0] ADDR_SCRATCH_D = 6'h13;
    localparam logic [5:0] ADDR_TIME_TRIM = 6'h14;
    localparam logic [5:0] ADDR_ALARM_DIS = 6'h15;

    // Word and field layout.
    localparam int DATA_W      = 24;
    localparam int SECS_W      = 17;
    localparam int SECS_LSB    = 0;
    localparam int TRIM_LSB    = 17;
    localparam int TRIM_W      = 5;
    localparam int MODE_LSB    = 22;
    localparam int MODE_W      = 2;
    localparam int STOP_BIT    = 23;
    localparam int SCRATCH_N   = 3;

    // Reset values.
    localparam logic [23:0] SCRATCH_RST = 24'h000000;
    localparam logic [16:0] SECS_RST    = 17'h00000;
    localparam logic [16:0] ALARM_RST   = 17'h1FFFF;
    localparam logic [4:0]  TRIM_RST    = 5'h00;
    localparam logic [1:0]  MODE_RST    = 2'h0;

    // Last second of a day before the counter wraps.
    localparam logic [16:0] SECS_LAST   = 17'h1517F;

    // Time base: 32768 ticks of the backup oscillator make one second.
    localparam int          TICKS_PER_SEC = 32768;
    localparam logic [15:0] TICK_LAST     = 16'h7FFF;

    // Calibration modes.
    typedef enum logic [1:0]
    {
        RTAB_TRIM_OFF  = 2'b00,
        RTAB_TRIM_ADD  = 2'b01,
        RTAB_TRIM_SUB  = 2'b10,
        RTAB_TRIM_RSVD = 2'b11
    } rtab_trim_e;

endpackage : rtab_pkg

/* File: rtab_prescaler.sv */
`timescale 1ns/10ps
// Divides the 32 kHz tick down to one pulse per second, with trim.
module rtab_prescaler
(
    // Clock and backup reset.
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // Tick link.
    rtab_tick_if.master      tick
);

    logic [15:0] ticks;
    logic [15:0] next_ticks;
    logic        pulse;
    logic        next_pulse;
    logic [15:0] last;

    // Trim moves the end of the count; this shifts each second by a few ticks.
    always_comb
    begin
        unique case (rtab_pkg::rtab_trim_e'(tick.trim_mode))
            rtab_pkg::RTAB_TRIM_ADD:  last = rtab_pkg::TICK_LAST + 16'(tick.trim_count);
            rtab_pkg::RTAB_TRIM_SUB:  last = rtab_pkg::TICK_LAST - 16'(tick.trim_count);
            rtab_pkg::RTAB_TRIM_OFF,
            rtab_pkg::RTAB_TRIM_RSVD: last = rtab_pkg::TICK_LAST;
        endcase
    end

    // Counting stops while the clock is stopped; the fraction is held.
    always_comb
    begin
        next_ticks = ticks;
        next_pulse = 1'b0;
        if (tick.run && tick.tick_32k)
        begin
            if (ticks >= last)
            begin
                next_ticks = 16'h0000;
                next_pulse = 1'b1;
            end
            else
            begin
                next_ticks = ticks + 16'h0001;
            end
        end
    end

    // Prescaler registers.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ticks <= 16'h0000;
            pulse <= 1'b0;
        end
        else
        begin
            ticks <= next_ticks;
            pulse <= next_pulse;
        end
    end

    assign tick.sec_pulse = pulse;

endmodule : rtab_prescaler

/* File: rtab_tick_if.sv */
`timescale 1ns/10ps
// Link from the second prescaler to the counter logic.
interface rtab_tick_if;
    logic       tick_32k;
    logic       run;
    logic [4:0] trim_count;
    logic [1:0] trim_mode;
    logic       sec_pulse;

    modport master
    (
        input  tick_32k,
        input  run,
        input  trim_count,
        input  trim_mode,
        output sec_pulse
    );
    modport ctrl
    (
        output tick_32k,
        output run,
        output trim_count,
        output trim_mode,
        input  sec_pulse
    );
endinterface : rtab_tick_if

/* File: rtab_time_alarm.sv */
`timescale 1ns/10ps
// What this block does
// - Register 0x11 is a 24-bit scratch word, cleared only by backup reset.
// - Register 0x12 is a 24-bit scratch word, cleared only by backup reset.
// - Register 0x13 is a 24-bit scratch word, cleared only by backup reset.
// - Register 0x14 bits 16..0 hold seconds of day, zero after backup reset.
// - Register 0x14 bits 21..17 hold the five-bit trim count, default zero.
// - Register 0x14 bits 23..22 hold the trim mode, default zero.
// - Register 0x15 bits 16..0 hold the alarm second, all ones after reset.
// - Global reset leaves all these registers unchanged.
module rtab_time_alarm
(
    // Clock and backup-domain power-on reset.
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // Global reset of the rest of the device; no effect here.
    input  wire logic        i_global_reset,
    // Backup oscillator tick, one cycle per 32 kHz period.
    input  wire logic        i_tick_32k,
    // Register access from the serial control interface.
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [5:0]  i_addr,
    input  wire logic [23:0] i_wdata,
    // Read data, alarm event and run status.
    output logic [23:0]      o_rdata,
    output logic             o_rvalid,
    output logic             o_time_alarm,
    output logic             o_clock_running
);

    // Word shown on the read bus whenever no read is being answered.
    localparam logic [23:0] IDLE_WORD = 24'h000000;

    // Backup-domain state. Everything here survives the global reset, so a
    // host that restarts the rest of the device finds its time and notes intact.
    logic [23:0] scratch [rtab_pkg::SCRATCH_N];
    logic [23:0] next_scratch [rtab_pkg::SCRATCH_N];
    logic [16:0] seconds_of_day;
    logic [16:0] next_seconds_of_day;
    logic [4:0]  trim_count;
    logic [4:0]  next_trim_count;
    logic [1:0]  trim_mode;
    logic [1:0]  next_trim_mode;
    logic [16:0] seconds_alarm;
    logic [16:0] next_seconds_alarm;
    logic        clock_stop;
    logic        next_clock_stop;

    // Staging for the registered outputs; every output leaves from a flop so
    // the pins stay clean while the mux and the compare settle.
    logic [23:0] next_rdata;
    logic        next_rvalid;
    logic        next_alarm;
    logic        next_running;
    logic        sec_pulse;

    // Host view of the two clock words:
    //   time word  = {trim mode, trim count, seconds of day}
    //   alarm word = {clock stop, six zero bits, alarm second}
    rtab_tick_if tick ();

    // Prescaler link. The stop bit gates the prescaler itself, so the part
    // of a second already counted is kept and the clock resumes where it
    // stopped rather than starting a fresh second.
    assign tick.tick_32k   = i_tick_32k;
    assign tick.run        = ~clock_stop;
    assign tick.trim_count = trim_count;
    assign tick.trim_mode  = trim_mode;
    assign sec_pulse       = tick.sec_pulse;

    rtab_prescaler u_prescaler
    (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .tick   (tick.master)
    );

    // Scratch words; one slot per address, host write is the only source.
    // Nothing in the device reads them; they keep notes for software only,
    // which is why a single write port and no read side effects suffice.
    generate
        for (genvar g = 0; g < rtab_pkg::SCRATCH_N; g++)
        begin : g_scratch
            always_comb
            begin
                next_scratch[g] = scratch[g];
                if (i_wr && i_addr == rtab_pkg::ADDR_SCRATCH_B + 6'(g))
                begin
                    next_scratch[g] = i_wdata;
                end
            end

            // Only the backup reset clears them, never the global reset.
            always_ff @(posedge i_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    scratch[g] <= rtab_pkg::SCRATCH_RST;
                end
                else
                begin
                    scratch[g] <= next_scratch[g];
                end
            end
        end
    endgenerate

    // Time, trim and alarm fields. A host write to the time wins over a
    // second that elapses in the same cycle, so software sets exact values.
    always_comb
    begin
        next_seconds_of_day = seconds_of_day;
        next_trim_count     = trim_count;
        next_trim_mode      = trim_mode;
        next_seconds_alarm  = seconds_alarm;
        next_clock_stop     = clock_stop;
        // A pulse already in flight when the stop bit lands is dropped; the
        // prescaler freezes in the same cycle, so no more than that one is lost.
        if (sec_pulse && !clock_stop)
        begin
            // Compare with at-or-above so a value written past the end of the
            // day still wraps at the next second instead of running on.
            if (seconds_of_day >= rtab_pkg::SECS_LAST)
            begin
                next_seconds_of_day = rtab_pkg::SECS_RST;
            end
            else
            begin
                next_seconds_of_day = seconds_of_day + 17'h00001;
            end
        end
        if (i_wr && i_addr == rtab_pkg::ADDR_TIME_TRIM)
        begin
            next_seconds_of_day = i_wdata[rtab_pkg::SECS_LSB +: rtab_pkg::SECS_W];
            next_trim_count     = i_wdata[rtab_pkg::TRIM_LSB +: rtab_pkg::TRIM_W];
            next_trim_mode      = i_wdata[rtab_pkg::MODE_LSB +: rtab_pkg::MODE_W];
        end
        if (i_wr && i_addr == rtab_pkg::ADDR_ALARM_DIS)
        begin
            next_seconds_alarm = i_wdata[rtab_pkg::SECS_LSB +: rtab_pkg::SECS_W];
            next_clock_stop    = i_wdata[rtab_pkg::STOP_BIT];
        end
    end

    // Clock registers stay put under the global reset input.
    // Trim count and mode are plain storage here; the prescaler applies
    // them, so a new trim takes effect on the second already being counted.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            seconds_of_day <= rtab_pkg::SECS_RST;
            trim_count     <= rtab_pkg::TRIM_RST;
            trim_mode      <= rtab_pkg::MODE_RST;
            seconds_alarm  <= rtab_pkg::ALARM_RST;
            clock_stop     <= 1'b0;
        end
        else
        begin
            seconds_of_day <= next_seconds_of_day;
            trim_count     <= next_trim_count;
            trim_mode      <= next_trim_mode;
            seconds_alarm  <= next_seconds_alarm;
            clock_stop     <= next_clock_stop;
        end
    end

    // Read mux. Reads have no side effects, so the host may poll any word
    // as often as it likes; unmapped addresses answer with the idle word.
    always_comb
    begin
        next_rdata  = IDLE_WORD;
        next_rvalid = i_rd;
        if (i_rd)
        begin
            unique case (i_addr)
                rtab_pkg::ADDR_SCRATCH_B: next_rdata = scratch[0];
                rtab_pkg::ADDR_SCRATCH_C: next_rdata = scratch[1];
                rtab_pkg::ADDR_SCRATCH_D: next_rdata = scratch[2];
                rtab_pkg::ADDR_TIME_TRIM: next_rdata = {trim_mode, trim_count, seconds_of_day};
                rtab_pkg::ADDR_ALARM_DIS: next_rdata = {clock_stop, 6'h00, seconds_alarm};
                default:                  next_rdata = IDLE_WORD;
            endcase
        end
    end

    // Alarm event and run status. The alarm is a one-cycle event on the
    // second that brings the counter onto the alarm value, so it does not
    // repeat every cycle of that second. Writing the time onto the alarm
    // value raises nothing unless a second elapses in that same cycle, and
    // a freshly written alarm is compared from the next second on.
    always_comb
    begin
        next_alarm   = (sec_pulse && !clock_stop
                        && next_seconds_of_day == seconds_alarm);
        next_running = ~clock_stop;
    end

    // Output registers. All outputs read zero while the backup reset is
    // held, so the host sees no stale alarm when the domain powers up.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_rdata         <= 24'h000000;
            o_rvalid        <= 1'b0;
            o_time_alarm    <= 1'b0;
            o_clock_running <= 1'b0;
        end
        else
        begin
            o_rdata         <= next_rdata;
            o_rvalid        <= next_rvalid;
            o_time_alarm    <= next_alarm;
            o_clock_running <= next_running;
        end
    end

endmodule : rtab_time_alarm

/* File: rtab_time_alarm_checker.sv */
`timescale 1ns/10ps
// Watches the register port and the event outputs of the clock block.
module rtab_time_alarm_checker
(
    // Clock and backup reset.
    input wire logic        i_clk,
    input wire logic        i_nrst,
    // Requests.
    input wire logic        i_global_reset,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [5:0]  i_addr,
    input wire logic [23:0] i_wdata,
    // Answers and events.
    input wire logic [23:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic        o_time_alarm,
    input wire logic        o_clock_running
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // Write to scratch word b, an idle cycle, then a read of it.
    sequence s_wr_rd_b;
        i_wr && i_addr == rtab_pkg::ADDR_SCRATCH_B ##1 !i_wr
            ##1 i_rd && !i_wr && i_addr == rtab_pkg::ADDR_SCRATCH_B;
    endsequence
    // Stop bit set, then no further alarm word write.
    sequence s_stop_set;
        i_wr && i_addr == rtab_pkg::ADDR_ALARM_DIS && i_wdata[rtab_pkg::STOP_BIT]
            ##1 !(i_wr && i_addr == rtab_pkg::ADDR_ALARM_DIS);
    endsequence

    rd_answer_a: assert property (i_rd |=> o_rvalid)
        else $error("read not answered");
    rvalid_cause_a: assert property (o_rvalid |-> $past(i_rd))
        else $error("answer without read");
    rdata_idle_a: assert property (!o_rvalid |-> o_rdata == 24'h000000)
        else $error("read data not idle");
    scratch_back_a: assert property (s_wr_rd_b |=> o_rdata == $past(i_wdata, 3))
        else $error("scratch word lost");
    unused_zero_a: assert property (i_rd && i_addr == rtab_pkg::ADDR_ALARM_DIS
        |=> o_rdata[22:17] == 6'h00) else $error("unused bits set");
    stop_takes_a: assert property (s_stop_set |=> !o_clock_running)
        else $error("clock not stopped");
    alarm_single_a: assert property (o_time_alarm |=> !o_time_alarm)
        else $error("alarm longer than one cycle");
    stopped_quiet_a: assert property (!o_clock_running [*3] |-> !o_time_alarm)
        else $error("alarm while stopped");
    global_keep_a: assert property (i_global_reset && !i_wr && !$past(i_wr)
        && o_clock_running |=> o_clock_running) else $error("global reset stopped clock");
endmodule : rtab_time_alarm_checker

bind rtab_time_alarm rtab_time_alarm_checker rtab_time_alarm_checker_inst
(
    .i_clk, .i_nrst, .i_global_reset, .i_wr, .i_rd, .i_addr, .i_wdata,
    .o_rdata, .o_rvalid, .o_time_alarm, .o_clock_running
);

/* File: testbench.sv */
`timescale 1ns/10ps
// Drives the clock block through its register port and checks what comes back.
module testbench;
    logic        i_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_global_reset = 1'b0;
    logic        i_tick_32k = 1'b0;
    logic        i_wr;
    logic        i_rd;
    logic [5:0]  i_addr;
    logic [23:0] i_wdata;
    logic [23:0] o_rdata;
    logic        o_rvalid;
    logic        o_time_alarm;
    logic        o_clock_running;
    int          k;
    int          n_errors = 0;
    int          compares = 0;
    // Rows: address, word written, word read back.
    logic [5:0]  r_a [8] = '{6'h11, 6'h12, 6'h13, 6'h14, 6'h14, 6'h14, 6'h15, 6'h16};
    logic [23:0] r_w [8] = '{24'hFFFFFF, 24'hA5A5A5, 24'h5A5A5A, 24'hBF517F,
                             24'h7E0000, 24'hC00000, 24'h7FFFFF, 24'hFFFFFF};
    logic [23:0] r_e [8] = '{24'hFFFFFF, 24'hA5A5A5, 24'h5A5A5A, 24'hBF517F,
                             24'h7E0000, 24'hC00000, 24'h01FFFF, 24'h000000};

    always #20 i_clk = ~i_clk;

    rtab_time_alarm rtab_time_alarm_inst
    (
        .i_clk, .i_nrst, .i_global_reset, .i_tick_32k, .i_wr, .i_rd, .i_addr,
        .i_wdata, .o_rdata, .o_rvalid, .o_time_alarm, .o_clock_running
    );
    rtab_host_model rtab_host_model_inst
    (
        .i_clk, .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr),
        .o_wdata(i_wdata)
    );

    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // Reads one word and compares it.
    task automatic rdchk(input string what, input logic [5:0] a, input logic [23:0] e);
        logic [23:0] d;
        rtab_host_model_inst.rd(a, d);
        chk(what, e, d);
    endtask : rdchk

    // Polls on the falling edge so the pulse has settled; bounded past one second.
    task automatic wait_alarm;
        k = 0;
        while (o_time_alarm !== 1'b1 && k < 33000)
        begin
            @(negedge i_clk);
            k++;
        end
        chk("alarm", 24'h000001, {23'h0, o_time_alarm});
    endtask : wait_alarm

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // Main sequence; ticks stay off until the counting tests so seconds hold still.
    initial
    begin
        repeat (20) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            rtab_host_model_inst.wr(r_a[i], r_w[i]);
            rdchk("row", r_a[i], r_e[i]);
        end
        i_global_reset = 1'b1;
        @(posedge i_clk);
        #1 i_global_reset = 1'b0;
        rdchk("keep", 6'h11, 24'hFFFFFF);
        $display("register tests done");
        i_nrst = 1'b0;
        repeat (2) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        for (int i = 0; i < 6; i++)
            rdchk("default", 6'(17 + i), (i == 4) ? 24'h01FFFF : 24'h000000);
        $display("reset test done");
        rtab_host_model_inst.wr(6'h14, 24'h000005);
        rtab_host_model_inst.wr(6'h15, 24'h800006);
        i_tick_32k = 1'b1;
        repeat (2000) @(posedge i_clk);
        #1 chk("running", 24'h000000, {23'h0, o_clock_running});
        rtab_host_model_inst.wr(6'h15, 24'h000006);
        wait_alarm;
        chk("late", 24'h000001, {23'h0, k > 32000});
        rdchk("second", 6'h14, 24'h000006);
        // Last second of the day, with the trim lengthening it by 31 ticks.
        rtab_host_model_inst.wr(6'h14, 24'h7F517F);
        rtab_host_model_inst.wr(6'h15, 24'h000000);
        wait_alarm;
        chk("long", 24'h000001, {23'h0, k > 32768});
        rdchk("wrap", 6'h14, 24'h7E0000);
        $display("counting tests done");
        end_of_test;
    end

    // Cuts a hang short well after the expected run of about 68000 cycles.
    initial
    begin
        #3200000;
        n_errors++;
        end_of_test;
    end
endmodule : testbench
